// File: verilog/lpt_tracker.sv
// Low power sequencing, turns accumulation and locked total position readout.
// Assumes angle samples arrive as one-cycle valid strobes and register strobes are one cycle.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module lpt_tracker
  import lpt_pkg::*;
#(
  parameter int PERIOD_CYC = 2500
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host driven pins.
  input wire logic wake_pin,
  input wire logic mosi,
  input wire logic sclk,
  input wire logic chip_select_n,
  // Angle paths and lock indication.
  input wire lpt_angle_t lp_sample,
  input wire lpt_angle_t fp_sample,
  input wire logic pll_locked,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Power control.
  output lpt_power_t power
);

  localparam logic [15:0] PERIOD_LAST = 16'(PERIOD_CYC - 1);
  localparam logic [IDLE_W-1:0] ENTRY_CNT = IDLE_W'(ENTRY_CYC);

  lpt_regs_t r;
  lpt_regs_t next_r;

  // Combinational helpers.
  logic ser_idle;
  logic wake_on;
  logic period_end;
  logic use_fp;
  logic take;
  logic [11:0] src_angle;
  logic [11:0] delta;
  logic [11:0] delta_abs;
  logic [24:0] sum;
  logic signed [12:0] turns;
  logic signed [12:0] t_max;
  logic signed [12:0] t_min;
  logic sat_hi;
  logic sat_lo;
  logic ovf_set;
  logic warn_set;
  logic turns_rst;

  // Sampled pin levels, only the second stage is looked at.
  assign ser_idle = (r.ser_s2 == 3'b000);
  assign wake_on = r.wake_s2;
  // The period counter wraps on its own, independent of state.
  assign period_end = (r.period_cnt == PERIOD_LAST);

  // Source choice: the full power path only exists in normal operation.
  assign use_fp = r.cfg[CFG_TCP] && (r.state == ST_NORMAL);
  assign src_angle = use_fp ? fp_sample.angle : lp_sample.angle;
  // Low power samples only count while that path is powered.
  assign take = use_fp ? fp_sample.valid : (lp_sample.valid && r.power.lp_path_en);

  // Sample-to-sample delta, wrapping modulo one turn.
  assign delta = src_angle - r.prev_angle;
  // A delta with the top bit set is a reverse rotation of up to 180 degrees.
  assign delta_abs = delta[11] ? 12'(-delta) : delta;
  assign sum = {r.position[23], r.position} + {{13{delta[11]}}, delta};
  assign turns = signed'(sum[24:12]);

  // Turns limits depend on the angle mode.
  assign t_max = r.cfg[CFG_MODE180] ? T180_MAX : T45_MAX;
  assign t_min = r.cfg[CFG_MODE180] ? T180_MIN : T45_MIN;
  assign sat_hi = turns > t_max;
  assign sat_lo = turns < t_min;

  assign ovf_set = take && !r.init_pending && (sat_hi || sat_lo);
  assign warn_set = take && !r.init_pending && (delta_abs > WARN_DELTA);
  assign turns_rst = reg_write && (reg_addr == ADDR_CTRL) && reg_wdata[CTRL_TURNS_RST];

  // Next state of the whole block.
  always_comb begin
    next_r = r;

    // Two-flop synchronizers for the host pins.
    next_r.wake_s1 = wake_pin;
    next_r.wake_s2 = r.wake_s1;
    next_r.ser_s1 = {mosi, sclk, chip_select_n};
    next_r.ser_s2 = r.ser_s1;

    // Free running sleep period counter.
    next_r.period_cnt = period_end ? 16'h0000 : 16'(r.period_cnt + 16'h0001);

    // Serial idle time, counted only in normal operation and held at the entry count.
    if (r.state != ST_NORMAL || !ser_idle) begin
      next_r.idle_cnt = '0;
    end else if (r.idle_cnt != ENTRY_CNT) begin
      next_r.idle_cnt = IDLE_W'(r.idle_cnt + 1'b1);
    end

    // Accumulator update on each accepted sample.
    if (take) begin
      next_r.prev_angle = src_angle;
      if (r.init_pending) begin
        // Start value: zero, or the present angle with zero turns.
        next_r.position = (r.cfg[CFG_INIT_LSB+:2] == INIT_ZERO) ? 24'h00_0000 : {12'h000, src_angle};
        next_r.init_pending = 1'b0;
        next_r.motion_low = 1'b1;
      end else begin
        next_r.motion_low = delta_abs < r.cfg[CFG_VEL_LSB+:ANG_W];
        if (sat_hi) begin
          next_r.position = {t_max[11:0], src_angle};
        end else if (sat_lo) begin
          next_r.position = {t_min[11:0], src_angle};
        end else begin
          next_r.position = sum[23:0];
        end
      end
    end

    // A turns reset restarts the accumulator at the next sample.
    if (turns_rst) begin
      next_r.init_pending = 1'b1;
    end

    // Sticky flags; a set in the same cycle beats a clear.
    if (ovf_set) begin
      next_r.ovf = 1'b1;
    end else if (turns_rst) begin
      next_r.ovf = 1'b0;
    end
    if (warn_set) begin
      next_r.warn = 1'b1;
    end else if (reg_write && reg_addr == ADDR_STATUS && reg_wdata[STAT_WARN]) begin
      next_r.warn = 1'b0;
    end

    // Register writes.
    if (reg_write) begin
      if (reg_addr == ADDR_CTRL) begin
        next_r.lp_cmd = reg_wdata[CTRL_LP_CMD];
      end else if (reg_addr == ADDR_CONFIG) begin
        next_r.cfg = reg_wdata;
      end
    end

    // Register reads, data valid in the following cycle only.
    next_r.rdata = 16'h0000;
    if (reg_read) begin
      if (reg_addr == ADDR_UPPER) begin
        next_r.rdata = {4'h0, r.position[23:12]};
        next_r.lock_lower = r.position[11:0];
      end else if (reg_addr == ADDR_LOWER) begin
        // Host must have read the upper half first for a matched pair.
        next_r.rdata = {4'h0, r.lock_lower};
      end else if (reg_addr == ADDR_CTRL) begin
        next_r.rdata = {15'h0000, r.lp_cmd};
      end else if (reg_addr == ADDR_STATUS) begin
        next_r.rdata = {14'h0000, r.warn, r.ovf};
      end else if (reg_addr == ADDR_ALIVE) begin
        next_r.rdata = r.alive;
      end else if (reg_addr == ADDR_CONFIG) begin
        next_r.rdata = r.cfg;
      end
    end

    // Power state machine.
    case (r.state)
      ST_NORMAL: begin
        if (r.idle_cnt == ENTRY_CNT && !wake_on && r.motion_low && r.lp_cmd) begin
          next_r.state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!ser_idle) begin
          next_r.state = ST_RELOCK;
        end else if (period_end && !wake_on && r.motion_low) begin
          next_r.state = ST_SLEEP;
          next_r.alive = 16'(r.alive + 16'h0001);
        end
        // Otherwise stay awake while fast or the wake pin is held.
      end
      ST_SLEEP: begin
        if (!ser_idle) begin
          next_r.state = ST_RELOCK;
        end else if (period_end || wake_on) begin
          next_r.state = ST_WAKE;
        end
      end
      ST_RELOCK: begin
        if (pll_locked) begin
          next_r.state = ST_NORMAL;
        end
      end
      default: begin
        next_r.state = ST_NORMAL;
      end
    endcase

    // Outputs follow the next state so they change with it.
    next_r.power = '0;
    next_r.power.lfo_en = 1'b1;
    case (next_r.state)
      ST_NORMAL: begin
        next_r.power.pll_en = 1'b1;
        next_r.power.serial_en = 1'b1;
        next_r.power.io_reg_en = 1'b1;
        next_r.power.lp_path_en = !next_r.cfg[CFG_TCP];
        next_r.power.angle_out_en = 1'b1;
      end
      ST_WAKE: begin
        next_r.power.out_tristate = 1'b1;
        next_r.power.lp_path_en = 1'b1;
      end
      ST_SLEEP: begin
        next_r.power.out_tristate = 1'b1;
      end
      ST_RELOCK: begin
        // Angle output stays off until the PLL reports lock.
        next_r.power.pll_en = 1'b1;
        next_r.power.serial_en = 1'b1;
        next_r.power.io_reg_en = 1'b1;
        next_r.power.lp_path_en = 1'b1;
      end
      default: begin
        next_r.power.out_tristate = 1'b1;
      end
    endcase
  end

  // State register; reset puts the accumulator into start-up.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.state <= ST_NORMAL;
      r.init_pending <= 1'b1;
      r.motion_low <= 1'b1;
      r.cfg <= CFG_RESET;
      r.power.pll_en <= 1'b1;
      r.power.serial_en <= 1'b1;
      r.power.io_reg_en <= 1'b1;
      r.power.lfo_en <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign power = r.power;

endmodule

// File: inc/lpt_pkg.sv
// Package of constants, types and register map for the low power turns tracker.
// Assumes a single 25 MHz clock and a plain address/strobe register port.
package lpt_pkg;

  // Clock rate and low power entry time.
  localparam int CLK_MHZ = 25;
  localparam int ENTRY_US = 64;
  localparam int ENTRY_CYC = ENTRY_US * CLK_MHZ;
  localparam int IDLE_W = 11;

  // Register offsets on the register port.
  localparam logic [7:0] ADDR_UPPER = 8'h36;
  localparam logic [7:0] ADDR_LOWER = 8'h38;
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h42;
  localparam logic [7:0] ADDR_ALIVE = 8'h44;
  localparam logic [7:0] ADDR_CONFIG = 8'h46;

  // Control register bits.
  localparam int CTRL_LP_CMD = 0;
  localparam int CTRL_TURNS_RST = 1;

  // Status register bits.
  localparam int STAT_OVF = 0;
  localparam int STAT_WARN = 1;

  // Configuration register layout and reset value.
  localparam int CFG_TCP = 0;
  localparam int CFG_MODE180 = 1;
  localparam int CFG_INIT_LSB = 2;
  localparam int CFG_VEL_LSB = 4;
  localparam logic [15:0] CFG_RESET = 16'h1001;
  localparam logic [1:0] INIT_ZERO = 2'h0;

  // Angle and position widths and thresholds, one LSB is 360/4096 degrees.
  localparam int ANG_W = 12;
  localparam int POS_W = 24;
  localparam logic [11:0] WARN_DELTA = 12'h600;
  localparam logic signed [12:0] T45_MAX = 13'sh07FF;
  localparam logic signed [12:0] T45_MIN = -13'sh0800;
  localparam logic signed [12:0] T180_MAX = 13'sh01FF;
  localparam logic signed [12:0] T180_MIN = -13'sh0200;

  // Power states.
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_WAKE = 2'b01,
    ST_SLEEP = 2'b10,
    ST_RELOCK = 2'b11
  } lpt_state_t;

  // One angle sample from a signal path.
  typedef struct packed {
    logic valid;
    logic [11:0] angle;
  } lpt_angle_t;

  // Power and pin control outputs.
  typedef struct packed {
    logic pll_en;
    logic serial_en;
    logic io_reg_en;
    logic out_tristate;
    logic lp_path_en;
    logic lfo_en;
    logic angle_out_en;
  } lpt_power_t;

  // Complete state of the tracker.
  typedef struct packed {
    lpt_state_t state;
    logic [IDLE_W-1:0] idle_cnt;
    logic [15:0] period_cnt;
    logic wake_s1;
    logic wake_s2;
    logic [2:0] ser_s1;
    logic [2:0] ser_s2;
    logic [11:0] prev_angle;
    logic init_pending;
    logic motion_low;
    logic [23:0] position;
    logic [11:0] lock_lower;
    logic ovf;
    logic warn;
    logic [15:0] alive;
    logic lp_cmd;
    logic [15:0] cfg;
    logic [15:0] rdata;
    lpt_power_t power;
  } lpt_regs_t;

endpackage

// File: bench/lpt_tracker_assertions.sv
// Checker for the tracker's register port and power sequencing.
// Assumes one clock domain and the active high reset of the tracker.
`timescale 1ns/1ps
module lpt_tracker_chk
  import lpt_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Host pins, samples and lock.
  input wire logic wake_pin,
  input wire logic mosi,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire lpt_angle_t lp_sample,
  input wire lpt_angle_t fp_sample,
  input wire logic pll_locked,
  // Register port and power outputs.
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire lpt_power_t power
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Sleep is the only state with tristated outputs and the low power path off.
  wire sleeping = power.out_tristate && !power.lp_path_en;
  wire relocking = power.pll_en && power.lp_path_en && !power.angle_out_en;
  wire idle_pins = !mosi && !sclk && !chip_select_n && !wake_pin;
  wire pos_read = reg_read && (reg_addr == ADDR_UPPER || reg_addr == ADDR_LOWER);

  // Pin decisions lag three edges because of the two synchronizer stages.
  property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
  property p_pos_pad; $past(pos_read) |-> reg_rdata[15:12] == 4'h0; endproperty
  a_pos_pad: assert property (p_pos_pad) else $error("position word top bits not zero");
  property p_lp_off; power.out_tristate |-> !power.pll_en && !power.serial_en && !power.io_reg_en; endproperty
  a_lp_off: assert property (p_lp_off) else $error("full power logic on in low power");
  property p_lfo_on; 1'b1 |-> power.lfo_en; endproperty
  a_lfo_on: assert property (p_lfo_on) else $error("slow oscillator stopped");
  property p_entry; $rose(power.out_tristate) && $past(power.angle_out_en) |-> $past(idle_pins, 3); endproperty
  a_entry: assert property (p_entry) else $error("low power entered with pins active");
  property p_sleep_gate; $rose(sleeping) |-> !$past(wake_pin, 3); endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep entered with wake pin high");
  property p_wake_exit; sleeping && wake_pin |-> ##[1:4] !sleeping; endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake pin did not end sleep");
  property p_relock; relocking && !pll_locked |=> !power.angle_out_en; endproperty
  a_relock: assert property (p_relock) else $error("angle output before lock");

  // Main scenarios.
  c_sleep: cover property ($rose(sleeping));
  c_relock: cover property (relocking ##1 power.angle_out_en);
  c_upper: cover property (reg_read && reg_addr == ADDR_UPPER);
endmodule

bind lpt_tracker lpt_tracker_chk lpt_tracker_chk_i (.clock, .rst, .wake_pin, .mosi, .sclk, .chip_select_n,
  .lp_sample, .fp_sample, .pll_locked, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .power);

// File: bench/lpt_host_model.sv
// Host model that drives the serial and wake pins as levels.
// Assumes the bench requests serial idle or activity and the wake level.
`timescale 1ns/1ps
module lpt_host_model (
  // Clock and requests from the bench.
  input wire logic clock,
  input wire logic go_idle,
  input wire logic wake_req,
  // Pins toward the tracker.
  output logic wake_pin = 1'b0,
  output logic mosi = 1'b0,
  output logic sclk = 1'b1,
  output logic chip_select_n = 1'b1
);
  // An active host keeps the device deselected with the clock high, so the pins leave all-zero.
  always @(posedge clock) begin
    wake_pin <= wake_req;
    sclk <= !go_idle;
    chip_select_n <= !go_idle;
    mosi <= 1'b0;
  end
endmodule

// File: bench/tb_top.sv
// Bench for the turns tracker: readout, turns counting, saturation and low power cycling.
// Assumes the host model on the pins and a sleep period shortened to 20 cycles.
`timescale 1ns/1ps
module tb_top;
  import lpt_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic go_idle = 1'b0;
  logic wake_req = 1'b0;
  logic pll_locked = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  lpt_angle_t lp_sample = '0;
  lpt_angle_t fp_sample = '0;
  logic wake_pin, mosi, sclk, chip_select_n;
  logic [15:0] reg_rdata;
  lpt_power_t power;
  int mismatches = 0;
  int check_count = 0;

  // A 20 ns half period gives 25 MHz.
  always #20 clock = ~clock;

  lpt_host_model lpt_host_model_i (.clock, .go_idle, .wake_req, .wake_pin, .mosi, .sclk, .chip_select_n);
  lpt_tracker #(.PERIOD_CYC(20)) lpt_tracker_i (.clock, .rst, .wake_pin, .mosi, .sclk, .chip_select_n,
    .lp_sample, .fp_sample, .pll_locked, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .power);

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are compared there.
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task smp(input logic [11:0] a);
    @(posedge clock);
    fp_sample <= '{valid: 1'b1, angle: a};
    @(posedge clock);
    fp_sample.valid <= 1'b0;
  endtask

  // A wrap past half a turn counts backwards, and the lower word keeps the value latched by the upper read.
  task t_pos;
    rd(ADDR_CONFIG, 16'h1001);
    rd(8'h50, 16'h0000);
    smp(12'h100);
    smp(12'h300);
    rd(ADDR_UPPER, 16'h0000);
    rd(ADDR_LOWER, 16'h0200);
    smp(12'hC00);
    rd(ADDR_UPPER, 16'h0FFF);
    smp(12'hC10);
    rd(ADDR_LOWER, 16'h0B00);
    rd(ADDR_STATUS, 16'h0002);
    wr(ADDR_STATUS, 16'h0002);
    rd(ADDR_STATUS, 16'h0000);
  endtask

  // Quarter turns in the narrow mode run the turns count past its top.
  task t_sat;
    wr(ADDR_CONFIG, 16'h1003);
    wr(ADDR_CTRL, 16'h0002);
    for (int i = 0; i < 2060; i++) smp(12'(i * 1024));
    rd(ADDR_UPPER, 16'h01FF);
    rd(ADDR_STATUS, 16'h0001);
    wr(ADDR_CTRL, 16'h0002);
    rd(ADDR_STATUS, 16'h0000);
    smp(12'h000);
    rd(ADDR_UPPER, 16'h0000);
  endtask

  // Idle pins start duty cycling; the wake pin holds it awake, serial activity relocks.
  task t_lp;
    int n;
    int sleeps;
    logic was;
    n = 0;
    sleeps = 0;
    was = 1'b0;
    wr(ADDR_CTRL, 16'h0001);
    lp_sample <= '{valid: 1'b1, angle: 12'h000};
    go_idle <= 1'b1;
    while (power.out_tristate !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk(16'(n >= 1600 && n < 1700), 16'h0001);
    for (int i = 0; i < 260; i++) begin
      @(posedge clock);
      if (i == 200) wake_req <= 1'b1;
      #1;
      if (power.out_tristate === 1'b1 && power.lp_path_en === 1'b0 && !was) sleeps++;
      was = (power.lp_path_en === 1'b0);
    end
    chk(16'(sleeps > 2), 16'h0001);
    chk({15'h0, power.lp_path_en}, 16'h0001);
    rd(ADDR_ALIVE, 16'(sleeps));
    @(posedge clock);
    pll_locked <= 1'b0;
    go_idle <= 1'b0;
    repeat (20) @(posedge clock);
    chk({15'h0, power.angle_out_en}, 16'h0000);
    pll_locked <= 1'b1;
    repeat (4) @(posedge clock);
    chk({15'h0, power.angle_out_en}, 16'h0001);
  endtask

  // With the low power path as the only source, start-up takes the present angle and full power samples are ignored.
  task t_src;
    wr(ADDR_CONFIG, 16'h1004);
    lp_sample <= '{valid: 1'b1, angle: 12'h123};
    wr(ADDR_CTRL, 16'h0002);
    smp(12'h800);
    rd(ADDR_UPPER, 16'h0000);
    rd(ADDR_LOWER, 16'h0123);
    rd(ADDR_STATUS, 16'h0000);
  endtask

  task summarize;
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_pos();
    t_sat();
    t_lp();
    t_src();
    summarize();
  end

  // The tests need about 6100 cycles, so 20000 means a hang.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    summarize();
  end
endmodule
